// file: logic/tic_pkg.sv
// constants shared by the transmit insertion control block
// Functional notes
// RQ1: signaling bit enables robbed-bit signaling on all non-transparent channels
// RQ2: signaling input replaces channel LSB in signaling frames
// RQ3: extended superframe CRC in frames 2,6,...,22
// RQ4: CRC pass-through clear inserts internally computed CRC
// RQ5: CRC pass-through set takes CRC from serial input
// RQ6: framing pass-through clear inserts generated framing bits
// RQ7: framing pass-through set takes framing from serial input
// RQ8: format bit clear gives dual-unipolar outputs
// RQ9: format bit set sends NRZ, negative held low
// RQ10: pin-controlled mode defaults to dual-unipolar output
// RQ11: transparent channels skip signaling and bit-7 suppression
// RQ12: transparent mask spans three registers, channels 1-24
// RQ13: idle-masked channel data replaced by selected idle code
// RQ14: idle non-transparent channels still get robbed signaling
// RQ15: idle mask spans three registers, same channel mapping
// RQ16: idle select chooses 7F when 0, FF when 1
// RQ17: blue alarm overrides everything, forced during loopback
// RQ18: compose data, idle, signaling, bit 7, then alarms, line code
package tic_pkg;

  // ***************************************************************
  // timing
  // ***************************************************************
  localparam int CLK_HZ  = 250_000_000;
  localparam int BIT_HZ  = 1_544_000;
  localparam int BIT_DIV = CLK_HZ / BIT_HZ;

  // ***************************************************************
  // register indices and fields
  // ***************************************************************
  localparam logic [2:0] REG_TX_CONTROL    = 3'h0;
  localparam logic [2:0] REG_TRANSP_CH1_8  = 3'h1;
  localparam logic [2:0] REG_TRANSP_CH9_16 = 3'h2;
  localparam logic [2:0] REG_TRANSP_CH17_24 = 3'h3;
  localparam logic [2:0] REG_IDLE_CH1_8    = 3'h4;
  localparam logic [2:0] REG_IDLE_CH9_16   = 3'h5;
  localparam logic [2:0] REG_IDLE_CH17_24  = 3'h6;
  localparam logic [2:0] REG_STATUS        = 3'h7;

  localparam int CTL_IDLE_SEL   = 3;
  localparam int CTL_SIG_EN     = 4;
  localparam int CTL_CRC_PASS   = 5;
  localparam int CTL_FRAME_PASS = 6;
  localparam int CTL_NRZ        = 7;

  localparam logic [7:0] CTL_RESET     = 8'h10;
  localparam logic [7:0] CTL_HW_MODE   = 8'h10;
  localparam logic [7:0] CTL_USED_MASK = 8'hf8;
  localparam logic [7:0] MASK_RESET    = 8'h00;

  localparam logic [7:0] IDLE_CODE_LOW  = 8'h7f;
  localparam logic [7:0] IDLE_CODE_HIGH = 8'hff;

  // ***************************************************************
  // frame structure
  // ***************************************************************
  localparam logic [4:0] LAST_SLOT      = 5'd24;
  localparam logic [2:0] LAST_BIT       = 3'd7;
  localparam logic [4:0] SF_LAST_FRAME  = 5'd11;
  localparam logic [4:0] ESF_LAST_FRAME = 5'd23;
  localparam logic [11:0] SF_F_PATTERN  = 12'h3b1;
  localparam logic [5:0] FPS_PATTERN    = 6'h34;
  localparam logic [5:0] CRC_POLY       = 6'h03;

  localparam int FIFO_DEPTH = 8;
  localparam int WORD_W     = 9;

endpackage

// file: logic/tic_fifo.sv
// word buffer between the system side and the frame composer
`timescale 1ns/1ps
module tic_fifo #(
  parameter int W     = 9,
  parameter int DEPTH = 8
) (
  input  wire logic         clk_sys,
  input  wire logic         resetn,
  input  wire logic [W-1:0] in_data,
  input  wire logic         in_valid,
  output logic              in_ready,
  output logic [W-1:0]      out_data,
  output logic              out_valid,
  input  wire logic         out_ready
);

  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [AW:0]  wr_ptr;
  logic [AW:0]  rd_ptr;
  logic         push;
  logic         pop;

  assign in_ready  = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
  assign out_valid = wr_ptr != rd_ptr;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[rd_ptr[AW-1:0]];

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      wr_ptr <= '0;
    end else if (push) begin
      wr_ptr <= wr_ptr + 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rd_ptr <= '0;
    end else if (pop) begin
      rd_ptr <= rd_ptr + 1'b1;
    end
  end

endmodule

// file: logic/tic_line_coder.sv
// line coder: AMI with optional B8ZS, or NRZ on the positive output
`timescale 1ns/1ps
module tic_line_coder (
  input  wire logic clk_sys,
  input  wire logic resetn,
  input  wire logic bit_in,
  input  wire logic bit_valid,
  input  wire logic b8zs_enable,
  input  wire logic nrz_select,
  output logic      line_pos,
  output logic      line_neg
);

  // symbol codes: none, normal mark, violation mark
  localparam logic [1:0] SYM_ZERO = 2'b00;
  localparam logic [1:0] SYM_MARK = 2'b01;
  localparam logic [1:0] SYM_VIOL = 2'b11;

  logic [1:0] pipe [8];
  logic [1:0] next_pipe [8];
  logic [2:0] zero_run;
  logic       last_pol;
  logic       substitute;
  logic [1:0] leaving;

  // eight-bit delay lets a run of zeros be rewritten before it leaves
  assign leaving    = pipe[7];
  assign substitute = b8zs_enable && !bit_in && (zero_run == 3'd7);

  always_comb begin
    for (int i = 1; i < 8; i++) begin
      next_pipe[i] = pipe[i-1];
    end
    next_pipe[0] = bit_in ? SYM_MARK : SYM_ZERO;
    if (substitute) begin // B8ZS: eight zeros sent as 000VB0VB
      next_pipe[4] = SYM_VIOL;
      next_pipe[3] = SYM_MARK;
      next_pipe[1] = SYM_VIOL;
      next_pipe[0] = SYM_MARK;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < 8; i++) begin
        pipe[i] <= SYM_ZERO;
      end
    end else if (bit_valid) begin
      pipe <= next_pipe;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      zero_run <= 3'd0;
    end else if (bit_valid) begin
      if (bit_in || substitute) begin
        zero_run <= 3'd0;
      end else if (zero_run != 3'd7) begin
        zero_run <= zero_run + 3'd1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      line_pos <= 1'b0;
      line_neg <= 1'b0;
      last_pol <= 1'b0;
    end else if (bit_valid) begin
      if (nrz_select) begin
        line_pos <= leaving != SYM_ZERO; // RQ9
        line_neg <= 1'b0; // RQ9
      end else if (leaving == SYM_MARK) begin
        line_pos <= !last_pol; // RQ8
        line_neg <= last_pol; // RQ8
        last_pol <= !last_pol;
      end else if (leaving == SYM_VIOL) begin
        // a violation repeats the previous polarity
        line_pos <= last_pol;
        line_neg <= !last_pol;
      end else begin
        line_pos <= 1'b0;
        line_neg <= 1'b0;
      end
    end
  end

endmodule

// file: logic/tic_top.sv
// transmit insertion control: frame composer, registers, buffer and coder
`timescale 1ns/1ps
module tic_top
  import tic_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       resetn,
  input  wire logic [2:0] reg_index,
  input  wire logic       reg_write,
  input  wire logic [7:0] reg_wdata,
  output logic [7:0]      reg_rdata,
  input  wire logic       hardware_mode,
  input  wire logic       extended_superframe_mode,
  input  wire logic       bit_seven_suppression,
  input  wire logic       b8zs_enable,
  input  wire logic       blue_alarm_request,
  input  wire logic       loopback_active,
  input  wire logic [7:0] tx_serial_data_input,
  input  wire logic       tx_signaling_input,
  input  wire logic       tx_word_valid,
  output logic            tx_word_ready,
  output logic            tx_frame_pulse,
  output logic            tx_positive_output,
  output logic            tx_negative_output
);

  // ***************************************************************
  // helpers
  // ***************************************************************
  function automatic logic mask_bit(input logic [23:0] mask, input logic [4:0] slot);
    logic hit;
    hit = 1'b0;
    if (slot != 5'd0 && slot <= LAST_SLOT) begin
      hit = mask[slot - 5'd1];
    end
    return hit;
  endfunction

  function automatic logic [5:0] crc_step(input logic [5:0] crc, input logic bit_in);
    logic fb;
    fb = crc[5] ^ bit_in;
    return {crc[4:0], 1'b0} ^ (fb ? CRC_POLY : 6'h00);
  endfunction

  // ***************************************************************
  // registers
  // ***************************************************************
  logic [7:0]  transmit_control_reg;
  logic [7:0]  transparent_mask_ch1_8;
  logic [7:0]  transparent_mask_ch9_16;
  logic [7:0]  transparent_mask_ch17_24;
  logic [7:0]  idle_mask_ch1_8;
  logic [7:0]  idle_mask_ch9_16;
  logic [7:0]  idle_mask_ch17_24;
  logic [7:0]  ctl;
  logic [23:0] transparent_mask;
  logic [23:0] idle_mask;
  logic [7:0]  status_value;
  logic [7:0]  next_rdata;

  // frame position
  logic [7:0]  div_cnt;
  logic        tick;
  logic        tick_pending;
  logic [2:0]  bit_cnt;
  logic [4:0]  slot;
  logic [4:0]  frame;
  logic [4:0]  frame_last;
  logic        need_word;
  logic        go;
  logic        starved;

  // buffer
  logic [WORD_W-1:0] fifo_out;
  logic              fifo_valid;
  logic              fifo_ready;
  logic [7:0]        word_data;
  logic              word_sig;

  // composition
  logic        chan_transparent;
  logic        chan_idle;
  logic        sig_frame;
  logic [7:0]  composed;
  logic [7:0]  held_byte;
  logic        framing_bit;
  logic        payload_bit;
  logic        line_bit;
  logic        blue_active;
  logic [5:0]  crc_run;
  logic [5:0]  crc_hold;
  logic        superframe_end;

  // pin-controlled mode ignores the software control register and falls back to fixed defaults
  assign ctl = hardware_mode ? CTL_HW_MODE : transmit_control_reg; // RQ10

  assign transparent_mask = {transparent_mask_ch17_24, transparent_mask_ch9_16,
                             transparent_mask_ch1_8}; // RQ12
  assign idle_mask        = {idle_mask_ch17_24, idle_mask_ch9_16, idle_mask_ch1_8}; // RQ15

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      transmit_control_reg <= CTL_RESET;
    end else if (reg_write && reg_index == REG_TX_CONTROL) begin
      transmit_control_reg <= reg_wdata & CTL_USED_MASK;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      transparent_mask_ch1_8   <= MASK_RESET;
      transparent_mask_ch9_16  <= MASK_RESET;
      transparent_mask_ch17_24 <= MASK_RESET;
    end else if (reg_write) begin
      if (reg_index == REG_TRANSP_CH1_8) begin
        transparent_mask_ch1_8 <= reg_wdata;
      end
      if (reg_index == REG_TRANSP_CH9_16) begin
        transparent_mask_ch9_16 <= reg_wdata;
      end
      if (reg_index == REG_TRANSP_CH17_24) begin
        transparent_mask_ch17_24 <= reg_wdata;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      idle_mask_ch1_8   <= MASK_RESET;
      idle_mask_ch9_16  <= MASK_RESET;
      idle_mask_ch17_24 <= MASK_RESET;
    end else if (reg_write) begin
      if (reg_index == REG_IDLE_CH1_8) begin
        idle_mask_ch1_8 <= reg_wdata;
      end
      if (reg_index == REG_IDLE_CH9_16) begin
        idle_mask_ch9_16 <= reg_wdata;
      end
      if (reg_index == REG_IDLE_CH17_24) begin
        idle_mask_ch17_24 <= reg_wdata;
      end
    end
  end

  assign status_value = {1'b0, starved, extended_superframe_mode, frame};

  always_comb begin
    unique case (reg_index)
      REG_TX_CONTROL:     next_rdata = ctl;
      REG_TRANSP_CH1_8:   next_rdata = transparent_mask_ch1_8;
      REG_TRANSP_CH9_16:  next_rdata = transparent_mask_ch9_16;
      REG_TRANSP_CH17_24: next_rdata = transparent_mask_ch17_24;
      REG_IDLE_CH1_8:     next_rdata = idle_mask_ch1_8;
      REG_IDLE_CH9_16:    next_rdata = idle_mask_ch9_16;
      REG_IDLE_CH17_24:   next_rdata = idle_mask_ch17_24;
      REG_STATUS:         next_rdata = status_value;
    endcase
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

  // ***************************************************************
  // bit timing
  // ***************************************************************
  assign tick = div_cnt == 8'(BIT_DIV - 1);

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      div_cnt <= 8'h00;
    end else if (tick) begin
      div_cnt <= 8'h00;
    end else begin
      div_cnt <= div_cnt + 8'h01;
    end
  end

  // a tick waits here while the buffer is empty; a new tick wins over the clear
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      tick_pending <= 1'b0;
    end else if (tick) begin
      tick_pending <= 1'b1;
    end else if (go) begin
      tick_pending <= 1'b0;
    end
  end

  assign need_word  = bit_cnt == 3'd0;
  assign go         = tick_pending && (!need_word || fifo_valid);
  assign fifo_ready = go && need_word;
  assign starved    = tick_pending && need_word && !fifo_valid;
  assign frame_last = extended_superframe_mode ? ESF_LAST_FRAME : SF_LAST_FRAME;
  assign superframe_end = go && slot == LAST_SLOT && bit_cnt == LAST_BIT
                          && frame >= frame_last;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      bit_cnt <= 3'd0;
      slot    <= 5'd0;
      frame   <= 5'd0;
    end else if (go) begin
      if (slot == 5'd0) begin
        slot <= 5'd1;
      end else if (bit_cnt != LAST_BIT) begin
        bit_cnt <= bit_cnt + 3'd1;
      end else begin
        bit_cnt <= 3'd0;
        if (slot != LAST_SLOT) begin
          slot <= slot + 5'd1;
        end else begin
          slot  <= 5'd0;
          frame <= (frame >= frame_last) ? 5'd0 : frame + 5'd1;
        end
      end
    end
  end

  // ***************************************************************
  // buffer
  // ***************************************************************
  tic_fifo #(
    .W     (WORD_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_sys   (clk_sys),
    .resetn    (resetn),
    .in_data   ({tx_signaling_input, tx_serial_data_input}),
    .in_valid  (tx_word_valid),
    .in_ready  (tx_word_ready),
    .out_data  (fifo_out),
    .out_valid (fifo_valid),
    .out_ready (fifo_ready)
  );

  assign word_data = fifo_out[7:0];
  assign word_sig  = fifo_out[8];

  // ***************************************************************
  // channel composition
  // ***************************************************************
  assign chan_transparent = mask_bit(transparent_mask, slot);
  assign chan_idle        = mask_bit(idle_mask, slot);
  assign sig_frame = frame == 5'd5 || frame == 5'd11 || frame == 5'd17 || frame == 5'd23;

  // order matters: idle first, then signaling, then the all-zero guard
  always_comb begin
    composed = word_data; // RQ18
    if (chan_idle) begin
      composed = ctl[CTL_IDLE_SEL] ? IDLE_CODE_HIGH : IDLE_CODE_LOW; // RQ13 RQ16
    end
    if (ctl[CTL_SIG_EN] && sig_frame && !chan_transparent) begin // RQ1 RQ11 RQ14
      composed[0] = word_sig; // RQ2
    end
    if (bit_seven_suppression && !chan_transparent && composed == 8'h00) begin // RQ11
      composed[1] = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      held_byte <= 8'h00;
    end else if (go && need_word && slot != 5'd0) begin
      held_byte <= composed;
    end
  end

  // ***************************************************************
  // framing bit
  // ***************************************************************
  always_comb begin
    framing_bit = 1'b1;
    if (!extended_superframe_mode) begin
      framing_bit = ctl[CTL_FRAME_PASS] ? word_data[0] : SF_F_PATTERN[frame[3:0]]; // RQ6 RQ7
    end else if (frame[1:0] == 2'd1) begin
      // frames 2, 6, ... 22 carry the previous superframe's check bits
      framing_bit = ctl[CTL_CRC_PASS] ? word_data[0] : crc_hold[3'd5 - frame[4:2]]; // RQ3 RQ4 RQ5
    end else if (frame[1:0] == 2'd3) begin
      framing_bit = ctl[CTL_FRAME_PASS] ? word_data[0] : FPS_PATTERN[frame[4:2]]; // RQ6 RQ7
    end
  end

  assign payload_bit = (slot == 5'd0) ? framing_bit
                     : (need_word ? composed[7] : held_byte[3'd7 - bit_cnt]);

  // ***************************************************************
  // check sequence over the outgoing superframe, framing bits taken as one
  // ***************************************************************
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      crc_run  <= 6'h00;
      crc_hold <= 6'h00;
    end else if (superframe_end) begin
      crc_hold <= crc_step(crc_run, payload_bit); // RQ4
      crc_run  <= 6'h00;
    end else if (go) begin
      crc_run <= crc_step(crc_run, (slot == 5'd0) ? 1'b1 : payload_bit);
    end
  end

  // ***************************************************************
  // alarms and line output
  // ***************************************************************
  assign blue_active = blue_alarm_request || loopback_active; // RQ17
  assign line_bit    = blue_active ? 1'b1 : payload_bit; // RQ17 RQ18

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      tx_frame_pulse <= 1'b0;
    end else begin
      tx_frame_pulse <= go && slot == 5'd0;
    end
  end

  tic_line_coder u_coder (
    .clk_sys     (clk_sys),
    .resetn      (resetn),
    .bit_in      (line_bit),
    .bit_valid   (go),
    .b8zs_enable (b8zs_enable),
    .nrz_select  (ctl[CTL_NRZ]),
    .line_pos    (tx_positive_output),
    .line_neg    (tx_negative_output)
  );

endmodule

// file: tb/tic_word_source.sv
// backplane model that feeds the framer one word per slot
`timescale 1ns/1ps
module tic_word_source (
  input  wire logic       clk_sys,
  input  wire logic       resetn,
  input  wire logic       pause,
  input  wire logic       ready,
  output logic [7:0]      data,
  output logic            sig,
  output logic            valid
);
  logic [4:0] slot;
  logic [4:0] next_slot;

  assign next_slot = (slot == 5'd24) ? 5'd0 : slot + 5'd1;

  // slot 0 sets the external framing bit high: it only counts under
  // pass-through, so a leak shows up as a wrong framing bit
  function automatic logic [7:0] word(input logic [4:0] s);
    return (s == 5'd0) ? 8'h01 : (s == 5'd1) ? 8'h5a : 8'h00;
  endfunction

  // released data toggles so a stale word is never mistaken for a live one
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      slot  <= 5'd0;
      valid <= 1'b0;
      data  <= 8'h00;
      sig   <= 1'b0;
    end else if (valid && ready) begin
      slot  <= next_slot;
      valid <= !pause;
      data  <= pause ? ~data : word(next_slot);
      sig   <= next_slot[0];
    end else if (!valid && !pause) begin
      valid <= 1'b1;
      data  <= word(slot);
      sig   <= slot[0];
    end else if (!valid) begin
      data  <= ~data;
    end
  end
endmodule

// file: tb/tic_top_checker.sv
// port assertions for the transmit insertion control top
`timescale 1ns/1ps
module tic_top_checker
  import tic_pkg::*;
(
  input wire logic       clk_sys,
  input wire logic       resetn,
  input wire logic [2:0] reg_index,
  input wire logic       reg_write,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic       hardware_mode,
  input wire logic       extended_superframe_mode,
  input wire logic       bit_seven_suppression,
  input wire logic       b8zs_enable,
  input wire logic       blue_alarm_request,
  input wire logic       loopback_active,
  input wire logic [7:0] tx_serial_data_input,
  input wire logic       tx_signaling_input,
  input wire logic       tx_word_valid,
  input wire logic       tx_word_ready,
  input wire logic       tx_frame_pulse,
  input wire logic       tx_positive_output,
  input wire logic       tx_negative_output
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  // ***************************************************************
  // settle counters: the coder delays each bit by eight bit times
  // ***************************************************************
  logic        nrz_on;
  logic [11:0] nrz_cnt;
  logic [11:0] blue_cnt;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) nrz_on <= 1'b0;
    else if (reg_write && reg_index == REG_TX_CONTROL) nrz_on <= reg_wdata[CTL_NRZ];
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) nrz_cnt <= 12'h000;
    else if (!nrz_on || hardware_mode) nrz_cnt <= 12'h000;
    else if (nrz_cnt != 12'hfff) nrz_cnt <= nrz_cnt + 12'h001;
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) blue_cnt <= 12'h000;
    else if (!(blue_alarm_request || loopback_active)) blue_cnt <= 12'h000;
    else if (blue_cnt != 12'hfff) blue_cnt <= blue_cnt + 12'h001;
  end

  // ***************************************************************
  // properties
  // ***************************************************************
  sequence s_mask_wr;
    reg_write && reg_index inside {[3'h1:3'h6]};
  endsequence
  sequence s_ctl_wr;
    reg_write && reg_index == REG_TX_CONTROL && !hardware_mode;
  endsequence
  sequence s_idx_held;
    !reg_write && $stable(reg_index);
  endsequence

  property p_mask_rd;
    s_mask_wr ##1 s_idx_held |=> reg_rdata == $past(reg_wdata, 2);
  endproperty
  property p_ctl_rd;
    s_ctl_wr ##1 (s_idx_held and !hardware_mode)
      |=> reg_rdata == ($past(reg_wdata, 2) & CTL_USED_MASK);
  endproperty
  property p_hw_ctl;
    $past(hardware_mode) && hardware_mode && reg_index == REG_TX_CONTROL
      |=> reg_rdata == CTL_HW_MODE;
  endproperty
  property p_status;
    $past(reg_index) == REG_STATUS && $stable(extended_superframe_mode)
      |-> !reg_rdata[7] && reg_rdata[5] == extended_superframe_mode;
  endproperty
  property p_no_both;
    !(tx_positive_output && tx_negative_output);
  endproperty
  property p_nrz_neg;
    nrz_cnt == 12'hfff |-> !tx_negative_output;
  endproperty
  property p_blue;
    blue_cnt == 12'hfff |-> tx_positive_output || tx_negative_output;
  endproperty
  property p_pulse;
    $rose(tx_frame_pulse) |=> (!tx_frame_pulse) [*8];
  endproperty

  a_mask_rd: assert property (p_mask_rd) else $error("mask readback wrong");
  a_ctl_rd: assert property (p_ctl_rd) else $error("control readback wrong");
  a_hw_ctl: assert property (p_hw_ctl) else $error("pin mode control wrong");
  a_status: assert property (p_status) else $error("status bits wrong");
  a_no_both: assert property (p_no_both) else $error("both rails high");
  a_nrz_neg: assert property (p_nrz_neg) else $error("negative rail active");
  a_blue: assert property (p_blue) else $error("alarm bit not a mark");
  a_pulse: assert property (p_pulse) else $error("frame pulse too long");
endmodule

bind tic_top tic_top_checker chk_u (
  .clk_sys(clk_sys), .resetn(resetn), .reg_index(reg_index),
  .reg_write(reg_write), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .hardware_mode(hardware_mode),
  .extended_superframe_mode(extended_superframe_mode),
  .bit_seven_suppression(bit_seven_suppression), .b8zs_enable(b8zs_enable),
  .blue_alarm_request(blue_alarm_request), .loopback_active(loopback_active),
  .tx_serial_data_input(tx_serial_data_input),
  .tx_signaling_input(tx_signaling_input), .tx_word_valid(tx_word_valid),
  .tx_word_ready(tx_word_ready), .tx_frame_pulse(tx_frame_pulse),
  .tx_positive_output(tx_positive_output),
  .tx_negative_output(tx_negative_output));

// file: tb/tic_top_bench.sv
// self-checking bench for the transmit insertion control top
`timescale 1ns/1ps
module tic_top_bench
  import tic_pkg::*;
;
  logic         clk_sys, resetn, wen, hw, esf, sup, blue, loop, pause;
  logic         ws, wv, rdy, fp, pos, neg, seen, lastp;
  logic [2:0]   idx;
  logic [7:0]   wdat, rdat, wd;
  logic [23:0]  tm, im;
  logic [192:0] f0, f1;
  logic [419:0] cap;
  logic [7:0]   mv [1:6] = '{8'h02, 8'h00, 8'h80, 8'h01, 8'h80, 8'h01};
  int           mismatches, n_checks, n, hit;

  assign tm = {mv[3], mv[2], mv[1]};
  assign im = {mv[6], mv[5], mv[4]};

  tic_top dut_u (
    .clk_sys(clk_sys), .resetn(resetn), .reg_index(idx), .reg_write(wen),
    .reg_wdata(wdat), .reg_rdata(rdat), .hardware_mode(hw),
    .extended_superframe_mode(esf), .bit_seven_suppression(sup),
    .b8zs_enable(1'b0), .blue_alarm_request(blue), .loopback_active(loop),
    .tx_serial_data_input(wd), .tx_signaling_input(ws), .tx_word_valid(wv),
    .tx_word_ready(rdy), .tx_frame_pulse(fp), .tx_positive_output(pos),
    .tx_negative_output(neg));

  tic_word_source src_u (.clk_sys(clk_sys), .resetn(resetn), .pause(pause),
    .ready(rdy), .data(wd), .sig(ws), .valid(wv));

  // ***************************************************************
  // tasks
  // ***************************************************************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR at %0t: seen %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [2:0] i, input logic [7:0] d);
    @(posedge clk_sys);
    idx  <= i;
    wdat <= d;
    wen  <= 1'b1;
    @(posedge clk_sys);
    wen  <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] i, input logic [7:0] m, input logic [7:0] e);
    @(posedge clk_sys);
    idx <= i;
    repeat (2) @(posedge clk_sys);
    #1 chk(rdat & m, e);
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // one frame as sent, framing bit first, channel words msb first
  function automatic logic [192:0] frame(input logic f, input logic [7:0] code);
    logic [192:0] v;
    logic [7:0]   w;
    v = '0;
    v[192] = f;
    for (int c = 1; c <= 24; c++) begin
      w = (c == 1) ? 8'h5a : 8'h00;
      if (im[c-1]) w = code;
      if (w == 8'h00 && !tm[c-1]) w = 8'h02;
      v[192-8*c +: 8] = w;
    end
    return v;
  endfunction

  // ***************************************************************
  // stimulus
  // ***************************************************************
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  initial begin
    repeat (96000) @(posedge clk_sys);
    mismatches++;
    close_out();
  end

  initial begin
    {wen, hw, esf, blue, loop, pause, seen, lastp} = '0;
    {sup, idx, wdat, resetn} = {1'b1, 3'h0, 8'h00, 1'b0};
    repeat (3) @(posedge clk_sys);
    resetn <= 1'b1;
    rd(REG_TX_CONTROL, 8'hff, CTL_RESET);
    for (int i = 1; i < 7; i++) begin
      rd(i[2:0], 8'hff, MASK_RESET);
      wr(i[2:0], mv[i]);
      rd(i[2:0], 8'hff, mv[i]);
    end
    wr(REG_TX_CONTROL, 8'h07);
    rd(REG_TX_CONTROL, 8'hff, 8'h00);
    chk(rdy, 1'b0);
    n = 0;
    while (fp !== 1'b1 && n < 1000) begin
      @(posedge clk_sys);
      #1 n++;
    end
    chk(fp, 1'b1);
    // sample mid bit; idle select flips after the idle channels of frame 0 are composed
    repeat (80) @(posedge clk_sys);
    for (int k = 0; k < 420; k++) begin
      if (k == 160) wr(REG_TX_CONTROL, 8'h08);
      repeat (k == 160 ? 159 : 161) @(posedge clk_sys);
      #1 cap[419-k] = pos | neg;
      if (pos | neg) begin
        if (seen) chk(pos, !lastp);
        seen = 1'b1;
        lastp = pos;
      end
    end
    f0 = frame(1'b1, IDLE_CODE_LOW);
    f1 = frame(1'b0, IDLE_CODE_HIGH);
    hit = -1;
    for (int i = 0; i < 32; i++)
      if (hit < 0 && cap[419-i -: 193] === f0) hit = i;
    chk(hit >= 0, 1'b1);
    if (hit >= 0) chk(cap[226-hit -: 193] === f1, 1'b1);
    wr(REG_TX_CONTROL, 8'h80);
    rd(REG_TX_CONTROL, 8'hff, 8'h80);
    blue <= 1'b1;
    repeat (3000) @(posedge clk_sys);
    #1 chk({pos, neg}, 2'b10);
    @(posedge clk_sys);
    blue <= 1'b0;
    loop <= 1'b1;
    repeat (2000) @(posedge clk_sys);
    #1 chk({pos, neg}, 2'b10);
    @(posedge clk_sys);
    loop <= 1'b0;
    hw   <= 1'b1;
    rd(REG_TX_CONTROL, 8'hff, CTL_HW_MODE);
    @(posedge clk_sys);
    hw    <= 1'b0;
    esf   <= 1'b1;
    pause <= 1'b1;
    repeat (14000) @(posedge clk_sys);
    rd(REG_STATUS, 8'he0, 8'h60);
    chk(rdy, 1'b1);
    close_out();
  end
endmodule
